// *** core/pcf_defines.svh ***
/*
 * Constants of the power channel fault supervisor: codes, offsets and times.
 * Assumes it is included by its bare name before the package and the module.
 */
// What this block does
// - standby regulator picks 3.3V or 5V and turns on by pin, GPIO or bus
// - chip is enabled while the chip-enable pin is high, disabled when low
// - soft-reset command over the serial bus resets the whole chip
// - channel enabled by stored default, assigned GPIO input or bus enable bit
// - per input, warn and fault levels in 100mV steps; warn sets a flag
// - input at or below its fault level sets fault flag and stops all channels
// - both input supply measurements readable at 100mV per LSB
// - optional automatic restart once input rises above the warning level
// - junction temperature reported in Kelvin, 5 K per LSB, 200K to 520K
// - over-temperature warning set within 5 or 10 degrees of the fault level
// - over-temperature sets fault and warning, stops channels, bus stays alive
// - shutdown temperature level is 7 bits at 5 K per LSB
// - optional restart after over-temperature below a separate restart level
// - channel target is code times 50mV; measured output readable back
// - overvoltage watched while the channel runs, soft-start included; trip stops channel, sets flag
// - overvoltage margin 150-300mV up to 2.5V, 300-600mV above
// - overvoltage trip also stops every channel set to follow the faulted one
// - overvoltage-stopped channels stay off until the host re-enables them or the chip-enable pin drops
// - any fault or warning can be mapped onto a GPIO output
// - overvoltage stop is passive, or forced with low-side drive held on
// - overcurrent stops the channel and restarts it after 200ms
// - chip enable raises a ready level letting the serial bus acknowledge
// - on chip enable, always-on and GPIO-asserted channels turn on
`ifndef PCF_DEFINES_SVH
`define PCF_DEFINES_SVH
`define PCF_NCH           4
`define PCF_TGT_2V5       8'h32
`define PCF_OV_LO_BASE    9'h003
`define PCF_OV_HI_BASE    9'h006
`define PCF_OT_MARGIN_5   8'h01
`define PCF_OT_MARGIN_10  8'h02
`define PCF_OCP_DELAY_MS  200
`define PCF_CLK_PERIOD_NS 100
`define PCF_NS_PER_MS     1000000
`define PCF_OCP_CNT_W     21
`define PCF_CNT_ONE       21'h000001
`define PCF_CNT_ZERO      21'h000000
`define PCF_FLAG_W        14
`endif

// *** core/pcf_pkg.sv ***
/*
 * Types of the power channel fault supervisor.
 * Assumes pcf_defines.svh is on the include path.
 */
`include "pcf_defines.svh"
package pcf_pkg;
	typedef enum logic [1:0] {CH_OFF, CH_RUN, CH_OV_HOLD, CH_OC_WAIT} pcf_ch_st_t;
	typedef struct packed {
		logic [7:0] target;
		logic [1:0] ov_sel;
		logic       forced;
		logic [3:0] follow;
	} pcf_ch_cfg_t;
	typedef struct packed {
		logic sel_5v;
		logic en_pin;
		logic en_gpio;
		logic en_bus;
	} pcf_stby_cfg_t;
	typedef struct packed {
		logic [1:0] uv_warn;
		logic [1:0] uv_fault;
		logic       ot_warn;
		logic       ot_fault;
		logic [3:0] ov_fault;
		logic [3:0] oc_fault;
	} pcf_flags_t;
endpackage

// *** core/pcf_supervisor.sv ***
/*
 * Supervisor of a four-channel step-down controller: enable, soft reset,
 * channel enable sources, standby regulator, undervoltage, temperature,
 * overvoltage and overcurrent handling with flags and a GPIO fault line.
 * Assumes all inputs are synchronous to clock and that measurements arrive
 * already converted; the serial bus engine lives outside.
 */
`timescale 1ns/1ps
`include "pcf_defines.svh"
module pcf_supervisor
	import pcf_pkg::*;
#(
	parameter int unsigned OCP_DELAY_CYCLES =
		`PCF_OCP_DELAY_MS * (`PCF_NS_PER_MS / `PCF_CLK_PERIOD_NS)
) (
	// clock and reset
	input  wire logic                    clock,
	input  wire logic                    reset,
	// chip control
	input  wire logic                    chip_enable_pin,
	input  wire logic                    soft_reset_command,
	// channel enable sources
	input  wire logic [3:0]              nvm_default_en,
	input  wire logic [3:0]              gpio_assign_en,
	input  wire logic [3:0]              gpio_in,
	input  wire logic [3:0]              channel_enable_bus_bits,
	// standby regulator
	input  pcf_stby_cfg_t                standby_regulator_config,
	input  wire logic                    standby_gpio_in,
	input  wire logic                    standby_bus_en,
	// input supplies, 100mV per LSB
	input  wire logic [7:0]              input_supply_one,
	input  wire logic [7:0]              input_supply_two,
	input  wire logic [1:0][7:0]         input_undervoltage_warn_level,
	input  wire logic [1:0][7:0]         input_undervoltage_fault_level,
	input  wire logic                    uv_auto_restart,
	// temperature, 5 K per LSB
	input  wire logic [6:0]              junction_temp,
	input  wire logic [6:0]              thermal_shutdown_level,
	input  wire logic [6:0]              thermal_restart_level,
	input  wire logic                    ot_margin_10,
	input  wire logic                    ot_auto_restart,
	// channels, 50mV per LSB
	input  pcf_ch_cfg_t [3:0]            ch_cfg,
	input  wire logic [3:0][7:0]         channel_voltage,
	input  wire logic [3:0]              oc_trip,
	input  wire logic [`PCF_FLAG_W-1:0]  gpio_flag_map,
	// outputs
	output logic                         chip_ready_q,
	output logic                         standby_regulator_output_q,
	output logic                         standby_sel_5v_q,
	output logic [3:0]                   channel_run_q,
	output logic [3:0]                   low_side_gate_drive_q,
	output logic [3:0][7:0]              channel_ref_code_q,
	output logic [3:0][7:0]              channel_voltage_measure_q,
	output logic [7:0]                   input_one_measure_q,
	output logic [7:0]                   input_two_measure_q,
	output logic [6:0]                   junction_temp_measure_q,
	output pcf_flags_t                   protection_flag_status_q,
	output logic                         fault_gpio_q
);

	// ==========================================================
	// overvoltage limit decode
	function automatic logic [8:0] ov_limit(input pcf_ch_cfg_t c);
		if (c.target <= `PCF_TGT_2V5)
			ov_limit = 9'(c.target) + `PCF_OV_LO_BASE + 9'(c.ov_sel);
		else
			ov_limit = 9'(c.target) + `PCF_OV_HI_BASE + 9'({c.ov_sel, 1'b0});
	endfunction

	logic        rst;
	logic        chip_on;
	logic [1:0]  uv_warn;
	logic [1:0]  uv_fault;
	logic        ot_hit;
	logic        ot_near;
	logic [3:0]  ov_trip;
	logic [3:0]  ov_hit;
	logic [3:0]  req;
	logic [3:0]  bus_rise;
	logic [7:0]  ot_margin;

	// soft reset acts exactly like the pin reset, one cycle wide is enough
	assign rst       = reset | soft_reset_command;
	assign ot_margin = ot_margin_10 ? `PCF_OT_MARGIN_10 : `PCF_OT_MARGIN_5;
	assign uv_warn   = {input_supply_two <= input_undervoltage_warn_level[1],
		input_supply_one <= input_undervoltage_warn_level[0]};
	assign uv_fault  = {input_supply_two <= input_undervoltage_fault_level[1],
		input_supply_one <= input_undervoltage_fault_level[0]};
	assign ot_hit    = junction_temp >= thermal_shutdown_level;
	assign ot_near   = 8'(junction_temp) + ot_margin >= 8'(thermal_shutdown_level);

	genvar g;
	generate
		for (g = 0; g < `PCF_NCH; g++) begin : g_trip
			// compared in every state so soft-start is covered too
			assign ov_trip[g] = 9'(channel_voltage[g]) > ov_limit(ch_cfg[g]);
			assign req[g] = nvm_default_en[g] | (gpio_assign_en[g] & gpio_in[g]) |
				channel_enable_bus_bits[g];
		end
	endgenerate

	// ==========================================================
	// chip level: enable, lockouts, input and temperature flags
	logic       uv_lock_q, uv_lock_d;
	logic       ot_lock_q, ot_lock_d;
	logic [1:0] uvw_q, uvw_d, uvf_q, uvf_d;
	logic       otw_q, otw_d, otf_q, otf_d;
	logic       ready_d, stby_d;

	// live faults count as well, so channels stop on the edge that sets the lockout
	assign chip_on = chip_enable_pin & ~uv_lock_q & ~ot_lock_q &
		~(|uv_fault) & ~ot_hit;

	always_comb begin
		ready_d = chip_enable_pin;
		stby_d  = (standby_regulator_config.en_pin & chip_enable_pin) |
			(standby_regulator_config.en_gpio & standby_gpio_in) |
			(standby_regulator_config.en_bus & standby_bus_en);
		// uv warn follows the live condition and ot warn holds with ot fault; fault flags hold in the warn band or not below the restart level, a new hit always wins
		uvw_d = uv_warn;
		uvf_d = uv_fault | (uvf_q & uv_warn);
		uv_lock_d = uv_lock_q;
		if (|uv_fault)
			uv_lock_d = 1'b1;
		else if (uv_lock_q && uv_auto_restart && !(|uv_warn))
			uv_lock_d = 1'b0;
		// the serial side keeps running; only channels see the lockout
		otf_d = ot_hit | (otf_q & ~(junction_temp < thermal_restart_level));
		otw_d = ot_near | otf_d;
		ot_lock_d = ot_lock_q;
		if (ot_hit)
			ot_lock_d = 1'b1;
		else if (ot_lock_q && ot_auto_restart && junction_temp < thermal_restart_level)
			ot_lock_d = 1'b0;
		// without auto restart a lockout waits for the enable pin to drop
		if (!chip_enable_pin) begin
			uv_lock_d = |uv_fault;
			ot_lock_d = ot_hit;
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			uv_lock_q                  <= 1'b0;
			ot_lock_q                  <= 1'b0;
			uvw_q                      <= 2'h0;
			uvf_q                      <= 2'h0;
			otw_q                      <= 1'b0;
			otf_q                      <= 1'b0;
			chip_ready_q               <= 1'b0;
			standby_regulator_output_q <= 1'b0;
			standby_sel_5v_q           <= 1'b0;
			input_one_measure_q        <= 8'h00;
			input_two_measure_q        <= 8'h00;
			junction_temp_measure_q    <= 7'h00;
		end else begin
			uv_lock_q                  <= uv_lock_d;
			ot_lock_q                  <= ot_lock_d;
			uvw_q                      <= uvw_d;
			uvf_q                      <= uvf_d;
			otw_q                      <= otw_d;
			otf_q                      <= otf_d;
			chip_ready_q               <= ready_d;
			standby_regulator_output_q <= stby_d;
			standby_sel_5v_q           <= standby_regulator_config.sel_5v;
			input_one_measure_q        <= input_supply_one;
			input_two_measure_q        <= input_supply_two;
			junction_temp_measure_q    <= junction_temp;
		end
	end

	// ==========================================================
	// per-channel state: run, overvoltage hold, overcurrent wait
	pcf_ch_st_t                     st_q [4];
	pcf_ch_st_t                     st_d [4];
	logic [`PCF_OCP_CNT_W-1:0]      cnt_q [4];
	logic [`PCF_OCP_CNT_W-1:0]      cnt_d [4];
	logic [3:0]                     ovf_q, ovf_d, ocf_q, ocf_d;
	logic [3:0]                     bus_q, run_d, gl_d;
	logic [3:0][7:0]                ref_d;
	pcf_flags_t                     flags_d;

	assign bus_rise = channel_enable_bus_bits & ~bus_q;
	generate
		for (g = 0; g < `PCF_NCH; g++) begin : g_hit
			assign ov_hit[g] = ov_trip[g] & (st_q[g] == CH_RUN);
		end
	endgenerate

	always_comb begin
		ovf_d = ovf_q;
		ocf_d = ocf_q;
		for (int i = 0; i < `PCF_NCH; i++) begin
			st_d[i]  = st_q[i];
			cnt_d[i] = cnt_q[i];
			case (st_q[i])
				CH_OFF: begin
					if (chip_on && req[i])
						st_d[i] = CH_RUN;
				end
				CH_RUN: begin
					if (!chip_on || !req[i])
						st_d[i] = CH_OFF;
					else if (oc_trip[i]) begin
						st_d[i]  = CH_OC_WAIT;
						cnt_d[i] = `PCF_CNT_ZERO;
						ocf_d[i] = 1'b1;
					end
				end
				CH_OV_HOLD: begin
					if (bus_rise[i] || !chip_enable_pin) begin
						st_d[i]  = CH_OFF;
						ovf_d[i] = 1'b0;
					end
				end
				CH_OC_WAIT: begin
					// counting starts the cycle the drivers go off
					cnt_d[i] = cnt_q[i] + `PCF_CNT_ONE;
					if (cnt_q[i] == `PCF_OCP_CNT_W'(OCP_DELAY_CYCLES - 1) || !chip_on) begin
						st_d[i]  = CH_OFF;
						ocf_d[i] = 1'b0;
					end
				end
				default: st_d[i] = CH_OFF;
			endcase
			// overvoltage and followers take priority over any move but leaving the overvoltage hold
			if (st_q[i] != CH_OV_HOLD && (ov_hit[i] || |(ch_cfg[i].follow & ov_hit)))
				st_d[i] = CH_OV_HOLD;
			if (ov_hit[i])
				ovf_d[i] = 1'b1;
			run_d[i] = st_d[i] == CH_RUN;
			gl_d[i]  = st_d[i] == CH_OV_HOLD && ch_cfg[i].forced;
			ref_d[i] = run_d[i] ? ch_cfg[i].target : 8'h00;
		end
		flags_d = '{uv_warn: uvw_d, uv_fault: uvf_d, ot_warn: otw_d,
			ot_fault: otf_d, ov_fault: ovf_d, oc_fault: ocf_d};
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			for (int i = 0; i < `PCF_NCH; i++) begin
				st_q[i]  <= CH_OFF;
				cnt_q[i] <= `PCF_CNT_ZERO;
			end
			ovf_q                     <= 4'h0;
			ocf_q                     <= 4'h0;
			bus_q                     <= 4'h0;
			channel_run_q             <= 4'h0;
			low_side_gate_drive_q     <= 4'h0;
			channel_ref_code_q        <= '0;
			channel_voltage_measure_q <= '0;
			protection_flag_status_q  <= '0;
			fault_gpio_q              <= 1'b0;
		end else begin
			st_q                      <= st_d;
			cnt_q                     <= cnt_d;
			ovf_q                     <= ovf_d;
			ocf_q                     <= ocf_d;
			bus_q                     <= channel_enable_bus_bits;
			channel_run_q             <= run_d;
			low_side_gate_drive_q     <= gl_d;
			channel_ref_code_q        <= ref_d;
			channel_voltage_measure_q <= channel_voltage;
			protection_flag_status_q  <= flags_d;
			fault_gpio_q              <= |(flags_d & gpio_flag_map);
		end
	end

	// ==========================================================
	// checks
	default clocking @(posedge clock); endclocking
	default disable iff (rst);

	sequence oc_enter_s(int k);
		st_q[k] == CH_RUN && chip_on && req[k] && oc_trip[k] && !(|ov_hit);
	endsequence
	sequence oc_held_s(int k);
		!channel_run_q[k] && protection_flag_status_q.oc_fault[k];
	endsequence

	chip_ready_a: assert property (chip_enable_pin |=> chip_ready_q)
		else $error("ready not raised after enable");
	uv_shutdown_a: assert property (|uv_fault |=> channel_run_q == 4'h0 &&
		protection_flag_status_q.uv_fault != 2'h0)
		else $error("undervoltage did not stop channels");
	ot_shutdown_a: assert property (ot_hit |=> channel_run_q == 4'h0 &&
		protection_flag_status_q.ot_fault && protection_flag_status_q.ot_warn)
		else $error("over-temperature did not stop channels");
	ot_warning_a: assert property (ot_near |=> protection_flag_status_q.ot_warn)
		else $error("temperature warning missing");
	standby_on_a: assert property (standby_regulator_config.en_bus && standby_bus_en
		|=> standby_regulator_output_q)
		else $error("standby regulator not switched on");

	generate
		for (g = 0; g < `PCF_NCH; g++) begin : g_chk
			ov_trip_a: assert property (ov_hit[g] |=> !channel_run_q[g] &&
				protection_flag_status_q.ov_fault[g])
				else $error("overvoltage did not stop channel");
			ov_follow_a: assert property (|(ch_cfg[g].follow & ov_hit) |=>
				!channel_run_q[g] ##1 !channel_run_q[g])
				else $error("follower channel still running");
			ov_hold_a: assert property (st_q[g] == CH_OV_HOLD && !bus_rise[g] &&
				chip_enable_pin |=> st_q[g] == CH_OV_HOLD)
				else $error("overvoltage hold left without host");
			oc_restart_a: assert property (oc_enter_s(g) |=> oc_held_s(g) [*8])
				else $error("overcurrent channel restarted too early");
			oc_count_a: assert property (st_q[g] == CH_OC_WAIT && chip_on && !(|ov_hit) &&
				cnt_q[g] == `PCF_OCP_CNT_W'(OCP_DELAY_CYCLES - 1) |=> st_q[g] == CH_OFF)
				else $error("overcurrent delay count wrong");
		end
	endgenerate

endmodule

// *** testbench/pcf_plant_model.sv ***
/*
 * Behavioural power stage behind the supervisor's channel outputs.
 * Assumes the bench drives the overshoot per channel and that clock is the
 * supervisor's clock; the sensed value is in 50mV codes.
 */
`timescale 1ns/1ps
module pcf_plant_model (
	// clock
	input  wire logic            clock,
	// reference from the supervisor, disturbance from the bench
	input  wire logic [3:0][7:0] ref_code,
	input  wire logic [3:0][7:0] overshoot,
	// sensed channel outputs
	output logic      [3:0][7:0] vout
);
	// ==========================================
	// output stage
	// ideal loop: settles in one cycle; a stopped channel reads zero plus the
	// disturbance, so an overshoot on an idle rail cannot be mistaken for a trip
	always_ff @(posedge clock) begin
		for (int i = 0; i < 4; i++) begin
			vout[i] <= ref_code[i] + overshoot[i];
		end
	end
endmodule

// *** testbench/tb_pcf_supervisor.sv ***
/*
 * Self-checking bench of the power channel fault supervisor.
 * Assumes pcf_pkg is compiled first and a short overcurrent delay is allowed.
 */
`timescale 1ns/1ps
module tb_pcf_supervisor
	import pcf_pkg::*;
;
	localparam int unsigned OVERCURRENT_PROTECTION = 20;
	logic                   clock = 1'h0;
	logic                   reset = 1'h1;
	logic                   chip_enable_pin, soft_reset_command, standby_gpio_in, standby_bus_en;
	logic                   uv_auto_restart, ot_margin_10, ot_auto_restart;
	logic [3:0]             nvm_default_en, gpio_assign_en, gpio_in, channel_enable_bus_bits;
	logic [3:0]             oc_trip;
	pcf_stby_cfg_t          standby_regulator_config;
	logic [7:0]             input_supply_one, input_supply_two;
	logic [1:0][7:0]        input_undervoltage_warn_level, input_undervoltage_fault_level;
	logic [6:0]             junction_temp, thermal_shutdown_level, thermal_restart_level;
	pcf_ch_cfg_t [3:0]      ch_cfg;
	logic [3:0][7:0]        channel_voltage, overshoot, channel_ref_code_q, channel_voltage_measure_q;
	logic [13:0]            gpio_flag_map;
	logic                   chip_ready_q, standby_regulator_output_q, standby_sel_5v_q, fault_gpio_q;
	logic [3:0]             channel_run_q, low_side_gate_drive_q;
	logic [7:0]             input_one_measure_q, input_two_measure_q;
	logic [6:0]             junction_temp_measure_q;
	pcf_flags_t             protection_flag_status_q;
	int                     failures = 0;
	int                     check_count = 0;
	int                     n;

	always #50 clock = ~clock;

	pcf_supervisor #(.OCP_DELAY_CYCLES(OVERCURRENT_PROTECTION)) pcf_supervisor_i (.clock, .reset, .chip_enable_pin,
		.soft_reset_command, .nvm_default_en, .gpio_assign_en, .gpio_in,
		.channel_enable_bus_bits, .standby_regulator_config, .standby_gpio_in, .standby_bus_en,
		.input_supply_one, .input_supply_two, .input_undervoltage_warn_level,
		.input_undervoltage_fault_level, .uv_auto_restart, .junction_temp,
		.thermal_shutdown_level, .thermal_restart_level, .ot_margin_10, .ot_auto_restart,
		.ch_cfg, .channel_voltage, .oc_trip, .gpio_flag_map, .chip_ready_q,
		.standby_regulator_output_q, .standby_sel_5v_q, .channel_run_q, .low_side_gate_drive_q,
		.channel_ref_code_q, .channel_voltage_measure_q, .input_one_measure_q,
		.input_two_measure_q, .junction_temp_measure_q, .protection_flag_status_q,
		.fault_gpio_q);

	pcf_plant_model pcf_plant_model_i (.clock, .ref_code(channel_ref_code_q), .overshoot,
		.vout(channel_voltage));

	// ==========================================
	// helpers
	task step(input int k);
		repeat (k) @(negedge clock);
	endtask

	task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			failures++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// bounded wait, the outcome itself is the comparison
	task wait_run(input int ch, input logic v);
		n = 0;
		while (channel_run_q[ch] !== v && n < 10) begin
			step(1);
			n++;
		end
		check("run wait", channel_run_q[ch], v);
	endtask

	task ov_case(input int ch, input logic [7:0] lim, input logic gl, input logic [3:0] rest,
			input logic gp);
		overshoot[ch] = lim;
		step(4);
		check("ov at limit", channel_run_q[ch], 1'h1);
		overshoot[ch] = lim + 8'h01;
		wait_run(ch, 1'h0);
		check("ov flag", protection_flag_status_q.ov_fault[ch], 1'h1);
		check("ov others", channel_run_q & 4'h7, rest);
		check("gate", low_side_gate_drive_q[ch], gl);
		check("fault pin", fault_gpio_q, gp);
		overshoot[ch] = 8'h00;
		step(5);
		check("ov hold", channel_run_q[ch], 1'h0);
		channel_enable_bus_bits[ch] = 1'h0;
		step(1);
		channel_enable_bus_bits[ch] = 1'h1;
		wait_run(ch, 1'h1);
		check("ov clear", protection_flag_status_q.ov_fault[ch], 1'h0);
		check("gate off", low_side_gate_drive_q[ch], 1'h0);
	endtask

	task ot_warn(input logic [6:0] t, input logic m, input logic exp);
		junction_temp = t;
		ot_margin_10 = m;
		step(2);
		check("ot warn", protection_flag_status_q.ot_warn, exp);
	endtask

	task end_of_test;
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	initial begin
		repeat (3000) @(posedge clock);
		failures++;
		end_of_test();
	end

	// ==========================================
	// scenarios
	initial begin
		{chip_enable_pin, soft_reset_command, standby_gpio_in, standby_bus_en} = 4'h0;
		{uv_auto_restart, ot_margin_10, ot_auto_restart} = 3'h5;
		{nvm_default_en, gpio_assign_en, gpio_in, channel_enable_bus_bits, oc_trip} = 20'h00000;
		input_supply_one = 8'h78;
		input_supply_two = 8'h78;
		input_undervoltage_warn_level = {8'h46, 8'h46};
		input_undervoltage_fault_level = {8'h3C, 8'h3C};
		junction_temp = 7'h3C;
		thermal_shutdown_level = 7'h50;
		thermal_restart_level = 7'h46;
		ch_cfg[0] = '{8'h32, 2'h0, 1'h1, 4'h0};
		ch_cfg[1] = '{8'h14, 2'h0, 1'h0, 4'h1};
		ch_cfg[2] = '{8'h40, 2'h1, 1'h0, 4'h0};
		ch_cfg[3] = '{8'h1E, 2'h0, 1'h0, 4'h0};
		overshoot = '0;
		gpio_flag_map = 14'h0010;
		standby_regulator_config = '{1'h1, 1'h1, 1'h0, 1'h0};
		step(2);
		reset = 1'h0;
		check("flags", protection_flag_status_q, 14'h0000);
		check("run", channel_run_q, 4'h0);
		nvm_default_en = 4'h1;
		gpio_assign_en = 4'h2;
		gpio_in = 4'h2;
		channel_enable_bus_bits = 4'h4;
		chip_enable_pin = 1'h1;
		step(1);
		check("ready", chip_ready_q, 1'h1);
		check("standby", standby_regulator_output_q, 1'h1);
		check("5v", standby_sel_5v_q, 1'h1);
		step(2);
		check("run", channel_run_q, 4'h7);
		check("ref", channel_ref_code_q[0], 8'h32);
		check("input_supply_one", input_one_measure_q, 8'h78);
		check("input_supply_two", input_two_measure_q, 8'h78);
		check("temp", junction_temp_measure_q, 7'h3C);
		check("vout", channel_voltage_measure_q[3], 8'h00);
		check("vout", channel_voltage_measure_q[2], 8'h40);
		gpio_in = 4'h0;
		step(2);
		check("gpio off", channel_run_q[1], 1'h0);
		gpio_in = 4'h2;
		standby_regulator_config = '{1'h0, 1'h0, 1'h1, 1'h0};
		standby_gpio_in = 1'h1;
		step(2);
		check("standby gpio", {standby_regulator_output_q, standby_sel_5v_q}, 2'h2);
		standby_gpio_in = 1'h0;
		step(2);
		check("standby off", standby_regulator_output_q, 1'h0);
		standby_regulator_config = '{1'h1, 1'h0, 1'h0, 1'h1};
		standby_bus_en = 1'h1;
		step(2);
		check("standby bus", {standby_regulator_output_q, standby_sel_5v_q}, 2'h3);
		standby_bus_en = 1'h0;
		ov_case(0, 8'h03, 1'h1, 4'h4, 1'h1);
		ov_case(2, 8'h08, 1'h0, 4'h1, 1'h0);
		// overcurrent on channel 2, counted from the tripping edge
		oc_trip = 4'h4;
		step(1);
		oc_trip = 4'h0;
		check("oc run", channel_run_q[2], 1'h0);
		check("oc flag", protection_flag_status_q.oc_fault[2], 1'h1);
		n = 1;
		while (channel_run_q[2] !== 1'h1 && n < 40) begin
			step(1);
			n++;
		end
		check("oc delay", n, OVERCURRENT_PROTECTION + 2);
		check("oc clear", protection_flag_status_q.oc_fault[2], 1'h0);
		// undervoltage: warn, fault, still locked inside the warn band, restart
		input_supply_one = 8'h46;
		step(2);
		check("uv warn", protection_flag_status_q.uv_warn, 2'h1);
		check("uv run", channel_run_q & 4'h5, 4'h5);
		input_supply_two = 8'h3C;
		step(2);
		check("uv fault", protection_flag_status_q.uv_fault, 2'h2);
		check("uv stop", channel_run_q, 4'h0);
		input_supply_two = 8'h40;
		step(3);
		check("uv lock", channel_run_q, 4'h0);
		check("uv latch", protection_flag_status_q.uv_fault, 2'h2);
		input_supply_one = 8'h78;
		input_supply_two = 8'h78;
		wait_run(0, 1'h1);
		check("uv clear", protection_flag_status_q.uv_fault, 2'h0);
		// temperature: margins, trip, restart level
		ot_warn(7'h4E, 1'h0, 1'h0);
		ot_warn(7'h4F, 1'h0, 1'h1);
		ot_warn(7'h4E, 1'h1, 1'h1);
		ot_warn(7'h4D, 1'h1, 1'h0);
		junction_temp = 7'h50;
		step(2);
		check("ot flags", {protection_flag_status_q.ot_warn, protection_flag_status_q.ot_fault},
			2'h3);
		check("ot stop", channel_run_q, 4'h0);
		check("ot ready", chip_ready_q, 1'h1);
		check("ot temp", junction_temp_measure_q, 7'h50);
		junction_temp = 7'h47;
		step(3);
		check("ot lock", channel_run_q, 4'h0);
		junction_temp = 7'h45;
		wait_run(0, 1'h1);
		check("ot clear", protection_flag_status_q.ot_fault, 1'h0);
		soft_reset_command = 1'h1;
		step(1);
		soft_reset_command = 1'h0;
		check("soft reset", {chip_ready_q, channel_run_q}, 5'h00);
		step(2);
		check("ready again", chip_ready_q, 1'h1);
		chip_enable_pin = 1'h0;
		step(2);
		check("disabled", {chip_ready_q, channel_run_q}, 5'h00);
		end_of_test();
	end
endmodule
